// ---- wkd_wake_detector.sv ----
/*
 Wake input detector top: register port, four filtered wake inputs,
 event and level status, interrupt, wake-up request and pull source control.
 Assumes comparator outputs arrive asynchronously and the cyclic sense
 windows come from on-chip logic on mclk.
*/
`timescale 1ns/1ps
module wkd_wake_detector
#(
    parameter logic [15:0] FILT_CYC_0 = wkd_pkg::FILT_CYC0,
    parameter logic [15:0] FILT_CYC_1 = wkd_pkg::FILT_CYC1,
    parameter logic [15:0] FILT_CYC_2 = wkd_pkg::FILT_CYC2,
    parameter logic [15:0] FILT_CYC_3 = wkd_pkg::FILT_CYC3
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [wkd_pkg::NWK-1:0] wake_input_pin,
    input wire logic [wkd_pkg::NWK-1:0] sense_window,
    output logic irq,
    output logic wake_up,
    output logic [wkd_pkg::NWK-1:0] pull_up_en,
    output logic [wkd_pkg::NWK-1:0] pull_dn_en
);
    import wkd_pkg::*;

    typedef struct packed
    {
        logic [31:0] ctrl;
        wkd_mode_t mode;
        logic sync_sel;
        logic fo_sel;
        logic [NWK-1:0] evt;
        logic [NWK-1:0] mask;
        logic [NWK-1:0] lvl;
        logic [31:0] rdata;
        logic irq;
        logic wake;
        logic [NWK-1:0] pu;
        logic [NWK-1:0] pd;
    } wkd_top_t;

    wkd_top_t q;
    wkd_top_t d;

    logic [NWK-1:0] pin_s;
    logic [NWK-1:0] blk;
    logic [NWK-1:0] wen;
    logic [NWK-1:0] cyc;
    logic [NWK-1:0] gate;
    logic [NWK-1:0] flt_lvl;
    logic [NWK-1:0] rise;
    logic [NWK-1:0] fall;
    logic [NWK-1:0] hit;
    logic [NWK-1:0] boot;
    logic [15:0] lim [NWK];

    // Pins are asynchronous to mclk
    wkd_sync u_sync
    (
        .mclk(mclk),
        .rst_b(rst_b),
        .din(wake_input_pin),
        .dout(pin_s)
    );

    // One filter per input with its own enable, gate and filter time
    for (genvar gi = 0; gi < NWK; gi++)
    begin : g_wk
        logic [1:0] fsel;
        assign fsel = q.ctrl[gi*CTRL_STRIDE+CTRL_FILT +: 2];
        // Alternate pin functions take the input away from wake detection
        assign blk[gi] = (gi == 3 && q.sync_sel) || (gi == 1 && q.fo_sel);
        assign wen[gi] = q.ctrl[gi*CTRL_STRIDE+CTRL_EN] && !blk[gi];
        assign cyc[gi] = q.ctrl[gi*CTRL_STRIDE+CTRL_CYC];
        assign gate[gi] = !cyc[gi] || sense_window[gi];
        assign lim[gi] = (fsel == 2'h0) ? FILT_CYC_0 :
                         (fsel == 2'h1) ? FILT_CYC_1 :
                         (fsel == 2'h2) ? FILT_CYC_2 : FILT_CYC_3;

        wkd_filt u_filt
        (
            .mclk(mclk),
            .rst_b(rst_b),
            .din(pin_s[gi]),
            .en(wen[gi]),
            .gate(gate[gi]),
            .lim(lim[gi]),
            .lvl(flt_lvl[gi]),
            .rise(rise[gi]),
            .fall(fall[gi])
        );
    end

    assign hit = rise | fall;

    // Enabled static inputs already high when leaving Init for Normal count as events
    always_comb
    begin
        boot = '0;
        if (reg_wr && reg_addr == ADDR_MODE && q.mode == WKD_INIT &&
            reg_wdata[2:0] == WKD_NORMAL)
            boot = wen & ~cyc & pin_s;
    end

    // Next state: register writes, status, levels, pulls, interrupt
    always_comb
    begin
        logic [1:0] ps;
        ps = 2'h0;
        d = q;
        d.rdata = 32'h0000_0000;

        // Writes
        if (reg_wr)
        begin
            case (reg_addr)
                ADDR_CTRL:
                    d.ctrl = reg_wdata;
                ADDR_MODE:
                begin
                    if (reg_wdata[2:0] <= WKD_FAILSAFE)
                        d.mode = wkd_mode_t'(reg_wdata[2:0]);
                    d.sync_sel = reg_wdata[MODE_SYNC];
                    d.fo_sel = reg_wdata[MODE_FO];
                end
                ADDR_MASK:
                    d.mask = reg_wdata[NWK-1:0];
                default:
                    d.ctrl = q.ctrl;
            endcase
        end

        // Sticky events: a new event wins over a clear in the same cycle
        if (reg_wr && reg_addr == ADDR_EVT)
            d.evt = q.evt & ~reg_wdata[NWK-1:0];
        d.evt = d.evt | hit | boot;

        // Level readback only in modes where software can read it
        if (q.mode == WKD_NORMAL || q.mode == WKD_STOP || q.mode == WKD_INIT)
        begin
            for (int i = 0; i < NWK; i++)
            begin
                if (blk[i])
                    d.lvl[i] = 1'b0;
                else if (!cyc[i])
                    d.lvl[i] = pin_s[i];
                else if (sense_window[i])
                    d.lvl[i] = pin_s[i];
            end
        end

        // Pull source decode; automatic mode follows the synchronised pin level
        for (int i = 0; i < NWK; i++)
        begin
            ps = q.ctrl[i*CTRL_STRIDE+CTRL_PULL +: 2];
            case (ps)
                PULL_NONE:
                begin
                    d.pu[i] = 1'b0;
                    d.pd[i] = 1'b0;
                end
                PULL_DOWN:
                begin
                    d.pu[i] = 1'b0;
                    d.pd[i] = 1'b1;
                end
                PULL_UP:
                begin
                    d.pu[i] = 1'b1;
                    d.pd[i] = 1'b0;
                end
                default:
                begin
                    d.pu[i] = pin_s[i];
                    d.pd[i] = !pin_s[i];
                end
            endcase
        end

        // Interrupt in active modes, wake-up request in low-power modes
        d.irq = |(d.evt & d.mask) && (d.mode == WKD_NORMAL || d.mode == WKD_STOP);
        d.wake = |d.evt && (d.mode == WKD_SLEEP || d.mode == WKD_FAILSAFE);

        // Read data stands only in the cycle after the strobe
        if (reg_rd)
        begin
            case (reg_addr)
                ADDR_CTRL:
                    d.rdata = q.ctrl;
                ADDR_MODE:
                    d.rdata = {27'h000_0000, q.fo_sel, q.sync_sel, q.mode};
                ADDR_EVT:
                    d.rdata = {28'h000_0000, q.evt};
                ADDR_LVL:
                    d.rdata = {28'h000_0000, q.lvl};
                ADDR_MASK:
                    d.rdata = {28'h000_0000, q.mask};
                default:
                    d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // Single state register
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            q <= '0;
            q.ctrl <= CTRL_RST;
            q.mode <= WKD_INIT;
            q.fo_sel <= FO_RST;
            q.mask <= MASK_RST;
        end
        else
            q <= d;
    end

    assign reg_rdata = q.rdata;
    assign irq = q.irq;
    assign wake_up = q.wake;
    assign pull_up_en = q.pu;
    assign pull_dn_en = q.pd;

    property p_evt_latch;
        @(posedge mclk) disable iff (!rst_b)
        |hit |=> ((q.evt & $past(hit)) == $past(hit));
    endproperty
    a_evt_latch: assert property (p_evt_latch) else $error("edge not recorded");

    property p_irq_active;
        @(posedge mclk) disable iff (!rst_b)
        (|(q.evt & q.mask) && q.mode == WKD_NORMAL && !reg_wr) |=> irq;
    endproperty
    a_irq_active: assert property (p_irq_active) else $error("interrupt missing");

    property p_wake_sleep;
        @(posedge mclk) disable iff (!rst_b)
        (q.mode == WKD_SLEEP && |hit && !reg_wr) |=> wake_up && !irq;
    endproperty
    a_wake_sleep: assert property (p_wake_sleep) else $error("wake-up missing");

    property p_sticky;
        @(posedge mclk) disable iff (!rst_b)
        (q.evt[0] && !(reg_wr && reg_addr == ADDR_EVT && reg_wdata[0])) |=> q.evt[0] [*1];
    endproperty
    a_sticky: assert property (p_sticky) else $error("event lost");

    property p_no_evt_disabled;
        @(posedge mclk) disable iff (!rst_b)
        (!q.ctrl[CTRL_EN] ##1 !q.ctrl[CTRL_EN]) |-> !hit[0];
    endproperty
    a_no_evt_disabled: assert property (p_no_evt_disabled) else $error("disabled input flagged");

    property p_pull_dn;
        @(posedge mclk) disable iff (!rst_b)
        (q.ctrl[CTRL_STRIDE+CTRL_PULL +: 2] == PULL_DOWN) |=> pull_dn_en[1] && !pull_up_en[1];
    endproperty
    a_pull_dn: assert property (p_pull_dn) else $error("pull-down not applied");

    property p_pull_auto;
        @(posedge mclk) disable iff (!rst_b)
        (q.ctrl[CTRL_STRIDE+CTRL_PULL +: 2] == PULL_AUTO) |=>
            pull_up_en[1] == $past(pin_s[1]) && pull_dn_en[1] != pull_up_en[1];
    endproperty
    a_pull_auto: assert property (p_pull_auto) else $error("automatic pull wrong");

    property p_sync_lvl;
        @(posedge mclk) disable iff (!rst_b)
        (q.sync_sel && q.mode == WKD_NORMAL) ##1 q.sync_sel |-> !q.lvl[3];
    endproperty
    a_sync_lvl: assert property (p_sync_lvl) else $error("level shown for sync input");

    property p_boot;
        @(posedge mclk) disable iff (!rst_b)
        |boot |=> ((q.evt & $past(boot)) == $past(boot)) && (irq || !(|($past(boot) & q.mask)));
    endproperty
    a_boot: assert property (p_boot) else $error("start-up event missing");

    // Read data stand for one cycle only; returning to zero keeps stale data from looking valid
    property p_rdata_idle;
        @(posedge mclk) disable iff (!rst_b)
        !reg_rd |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

    property p_mode_keep;
        @(posedge mclk) disable iff (!rst_b)
        (reg_wr && reg_addr == ADDR_MODE && reg_wdata[2:0] > WKD_FAILSAFE) |=> $stable(q.mode);
    endproperty
    a_mode_keep: assert property (p_mode_keep) else $error("undefined mode accepted");

    // Low-power modes never interrupt; their only answer is the wake-up request
    property p_wake_failsafe;
        @(posedge mclk) disable iff (!rst_b)
        (q.mode == WKD_FAILSAFE && |hit && !reg_wr) |=> wake_up && !irq;
    endproperty
    a_wake_failsafe: assert property (p_wake_failsafe) else $error("fail-safe wake-up missing");

    property p_irq_low_power;
        @(posedge mclk) disable iff (!rst_b)
        ((q.mode == WKD_SLEEP || q.mode == WKD_FAILSAFE) && !reg_wr) |=> !irq;
    endproperty
    a_irq_low_power: assert property (p_irq_low_power) else $error("interrupt in low-power mode");

    // Static inputs track the synchronised pin, cyclic ones hold their level outside the window
    property p_lvl_static;
        @(posedge mclk) disable iff (!rst_b)
        (q.mode == WKD_NORMAL && !cyc[0]) |=> q.lvl[0] == $past(pin_s[0]);
    endproperty
    a_lvl_static: assert property (p_lvl_static) else $error("static level not tracked");

    property p_lvl_cyc_hold;
        @(posedge mclk) disable iff (!rst_b)
        (cyc[2] && !sense_window[2]) |=> $stable(q.lvl[2]);
    endproperty
    a_lvl_cyc_hold: assert property (p_lvl_cyc_hold) else $error("cyclic level changed outside window");

    property p_fo_lvl;
        @(posedge mclk) disable iff (!rst_b)
        (q.fo_sel && q.mode != WKD_SLEEP && q.mode != WKD_FAILSAFE) ##1 q.fo_sel |-> !q.lvl[1];
    endproperty
    a_fo_lvl: assert property (p_fo_lvl) else $error("level shown for fail output");

    property p_pull_up;
        @(posedge mclk) disable iff (!rst_b)
        (q.ctrl[CTRL_STRIDE+CTRL_PULL +: 2] == PULL_UP) |=> pull_up_en[1] && !pull_dn_en[1];
    endproperty
    a_pull_up: assert property (p_pull_up) else $error("pull-up not applied");

    property p_pull_none;
        @(posedge mclk) disable iff (!rst_b)
        (q.ctrl[CTRL_PULL +: 2] == PULL_NONE) |=> !pull_up_en[0] && !pull_dn_en[0];
    endproperty
    a_pull_none: assert property (p_pull_none) else $error("pull source on without code");

    c_irq: cover property (@(posedge mclk) disable iff (!rst_b) $rose(irq));
    c_wake: cover property (@(posedge mclk) disable iff (!rst_b) $rose(wake_up));
    c_fall: cover property (@(posedge mclk) disable iff (!rst_b) |fall);
    c_boot: cover property (@(posedge mclk) disable iff (!rst_b) |boot);
    c_failsafe: cover property (@(posedge mclk) disable iff (!rst_b) q.mode == WKD_FAILSAFE && wake_up);
endmodule

// ---- wkd_pkg.sv ----
/*
 Constants, field layout, register map and types of the wake input detector.
 Assumes a single 250 MHz clock and a plain register port from the host logic.
*/
// Functional notes
// - Every wake input is edge sensitive; rising and falling edges both count.
// - An event raises the interrupt in Normal or Stop, a wake-up in Sleep or Fail-Safe.
// - Each input senses statically or cyclically, the latter only inside its window.
// - A crossing starts the filter; a wake counts only if no crossing back meanwhile.
// - Static sensing filters out short transients and disturbance pulses.
// - Software enables or disables wake detection on each input separately.
// - Every wake event is held in the event status register for software.
// - The level status register shows each pin level in Normal, Stop and Init.
// - In cyclic sensing the level status holds the level sampled in the last window.
// - No level readback on the fourth input as sync, nor the second as fail output.
// - Software selects pull current sources for every input in the control register.
// - Pull code 00 floats (reset), 01 pulls down, 10 pulls up.
// - Pull code 11 pulls up while the input is high, down while low.
// - A filter time selection per input sets the filter in both sensing modes.
// - Init to Normal with static sensing flags inputs already high, with interrupt.
// - The reference level resets low; only edges while enabled are flagged. Here a change made while disabled is flagged once enabled.
package wkd_pkg;
    localparam int NWK = 4;
    localparam int CLK_MHZ = 250;
    // Register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_EVT = 8'h08;
    localparam logic [7:0] ADDR_LVL = 8'h0c;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    // Control field positions, one byte per input
    localparam int CTRL_STRIDE = 8;
    localparam int CTRL_EN = 0;
    localparam int CTRL_PULL = 1;
    localparam int CTRL_CYC = 3;
    localparam int CTRL_FILT = 4;
    // Mode register field positions
    localparam int MODE_SYNC = 3;
    localparam int MODE_FO = 4;
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic FO_RST = 1'b1;
    localparam logic [3:0] MASK_RST = 4'h0;
    // Filter times in microseconds and in clock cycles
    localparam int FILT_US0 = 16;
    localparam int FILT_US1 = 32;
    localparam int FILT_US2 = 64;
    localparam int FILT_US3 = 128;
    localparam logic [15:0] FILT_CYC0 = 16'(FILT_US0 * CLK_MHZ);
    localparam logic [15:0] FILT_CYC1 = 16'(FILT_US1 * CLK_MHZ);
    localparam logic [15:0] FILT_CYC2 = 16'(FILT_US2 * CLK_MHZ);
    localparam logic [15:0] FILT_CYC3 = 16'(FILT_US3 * CLK_MHZ);
    // Pull source codes
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP = 2'h2;
    localparam logic [1:0] PULL_AUTO = 2'h3;
    // Device operating modes
    typedef enum logic [2:0]
    {
        WKD_INIT = 3'b000,
        WKD_NORMAL = 3'b001,
        WKD_STOP = 3'b010,
        WKD_SLEEP = 3'b011,
        WKD_FAILSAFE = 3'b100
    } wkd_mode_t;
endpackage

// ---- wkd_sync.sv ----
/*
 Two flip-flop synchroniser for the wake comparator outputs.
 Assumes the inputs are asynchronous to mclk.
*/
`timescale 1ns/1ps
module wkd_sync
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [wkd_pkg::NWK-1:0] din,
    output logic [wkd_pkg::NWK-1:0] dout
);
    import wkd_pkg::*;

    typedef struct packed
    {
        logic [NWK-1:0] s1;
        logic [NWK-1:0] s2;
    } wkd_sync_t;

    wkd_sync_t q;
    wkd_sync_t d;

    // First stage feeds only the second stage
    always_comb
    begin
        d.s1 = din;
        d.s2 = q.s1;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            q <= '0;
        else
            q <= d;
    end

    assign dout = q.s2;
endmodule

// ---- wkd_filt.sv ----
/*
 Filter and edge detector for one wake input.
 Assumes din is already synchronised and lim is at least one.
*/
`timescale 1ns/1ps
module wkd_filt
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic din,
    input wire logic en,
    input wire logic gate,
    input wire logic [15:0] lim,
    output logic lvl,
    output logic rise,
    output logic fall
);
    import wkd_pkg::*;

    typedef struct packed
    {
        logic held;
        logic [15:0] cnt;
        logic rise;
        logic fall;
    } wkd_filt_t;

    wkd_filt_t q;
    wkd_filt_t d;

    // Level must stay across the threshold for lim cycles
    always_comb
    begin
        d = q;
        d.rise = 1'b0;
        d.fall = 1'b0;
        if (!en || !gate)
            d.cnt = 16'h0000;
        else if (din == q.held)
            d.cnt = 16'h0000;
        else if (q.cnt >= lim - 16'h0001)
        begin
            d.held = din;
            d.cnt = 16'h0000;
            d.rise = din;
            d.fall = !din;
        end
        else
            d.cnt = q.cnt + 16'h0001;
    end

    // Reference level starts low so a high pin seen later counts
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            q <= '0;
        else
            q <= d;
    end

    assign lvl = q.held;
    assign rise = q.rise;
    assign fall = q.fall;

    property p_filt_time;
        @(posedge mclk) disable iff (!rst_b)
        $changed(q.held) |-> $past(q.cnt) == $past(lim) - 16'h0001;
    endproperty
    a_filt_time: assert property (p_filt_time) else $error("level taken before filter time");

    property p_hold_off;
        @(posedge mclk) disable iff (!rst_b)
        !en |=> $stable(q.held) && !q.rise && !q.fall;
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("disabled input changed reference");

    property p_glitch;
        @(posedge mclk) disable iff (!rst_b)
        (en && gate && din != q.held && q.cnt == 16'h0000 && lim > 16'h0002) ##1 (din == q.held)
        |=> $stable(q.held);
    endproperty
    a_glitch: assert property (p_glitch) else $error("short pulse accepted");
endmodule

// ---- wkd_pin_model.sv ----
/*
 Behavioural model of the external switch or sensor lines on the four wake pins.
 Assumes the bench decides per pin whether the line is driven; a released
 line follows the device's pull sources, or wanders when no source is on.
*/
`timescale 1ns/1ps
module wkd_pin_model
(
    input wire logic mclk,
    input wire logic [3:0] drive_en,
    input wire logic [3:0] drive_lvl,
    input wire logic [3:0] pull_up_en,
    input wire logic [3:0] pull_dn_en,
    output logic [3:0] pin
);
    logic [3:0] float_q;

    // A floating pin has no defined level, so it changes every cycle
    always_ff @(posedge mclk)
    begin
        float_q <= ~pin;
    end

    // Driven level wins, then the pull sources, else the wandering level
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (drive_en[i])
                pin[i] = drive_lvl[i];
            else if (pull_up_en[i])
                pin[i] = 1'b1;
            else if (pull_dn_en[i])
                pin[i] = 1'b0;
            else
                pin[i] = float_q[i];
        end
    end
endmodule

// ---- wkd_wake_detector_test.sv ----
/*
 Self-checking testbench of the wake input detector.
 Assumes short filter counts (4..7 cycles) and the register map of wkd_pkg.
*/
`timescale 1ns/1ps
module wkd_wake_detector_test;
    import wkd_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [3:0] sense_window = 4'h0;
    logic [3:0] drive_en = 4'hf;
    logic [3:0] drive_lvl = 4'h1;
    logic [3:0] pin;
    logic irq;
    logic wake_up;
    logic [3:0] pull_up_en;
    logic [3:0] pull_dn_en;
    int num_errors = 0;
    int compares = 0;

    wkd_wake_detector #(.FILT_CYC_0(16'h0004), .FILT_CYC_1(16'h0005), .FILT_CYC_2(16'h0006),
        .FILT_CYC_3(16'h0007)) dut
    (
        .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wake_input_pin(pin), .sense_window(sense_window),
        .irq(irq), .wake_up(wake_up), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en)
    );

    wkd_pin_model line
    (
        .mclk(mclk), .drive_en(drive_en), .drive_lvl(drive_lvl), .pull_up_en(pull_up_en),
        .pull_dn_en(pull_dn_en), .pin(pin)
    );

    // Clock at 250 MHz
    initial
    begin
        forever #2 mclk = ~mclk;
    end

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just after that edge
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp, "register read");
        @(posedge mclk);
        #1;
        chk(reg_rdata, 32'h0000_0000, "read data after its cycle");
    endtask

    task automatic set_pin(input int i, input logic v, input int n);
        @(posedge mclk);
        drive_lvl[i] <= v;
        repeat (n) @(posedge mclk);
    endtask

    task automatic t_reset();
        rd(ADDR_CTRL, CTRL_RST);
        rd(ADDR_MODE, 32'h0000_0010);
        rd(ADDR_EVT, 32'h0000_0000);
        rd(ADDR_MASK, 32'h0000_0000);
        rd(8'h20, 32'h0000_0000);
        chk({pull_up_en, pull_dn_en}, 32'h0000_0000, "pulls after reset");
    endtask

    task automatic t_init_normal();
        wr(ADDR_MASK, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_0001);
        wr(ADDR_MODE, 32'h0000_0001);
        repeat (2) @(posedge mclk);
        #1;
        chk(irq, 1'b1, "irq on entry to normal");
        rd(ADDR_EVT, 32'h0000_0001);
        repeat (20) @(posedge mclk);
        wr(ADDR_EVT, 32'h0000_0001);
        #1;
        chk(irq, 1'b0, "irq after clear");
        rd(ADDR_EVT, 32'h0000_0000);
    endtask

    // Input 2 uses the longest filter; a pulse the shortest filter would pass is dropped
    task automatic t_edges();
        wr(ADDR_CTRL, 32'h0031_0001);
        set_pin(2, 1'b1, 5);
        set_pin(2, 1'b0, 20);
        rd(ADDR_EVT, 32'h0000_0000);
        set_pin(2, 1'b1, 20);
        rd(ADDR_EVT, 32'h0000_0004);
        rd(ADDR_LVL, 32'h0000_0005);
        wr(ADDR_EVT, 32'h0000_0004);
        set_pin(2, 1'b0, 20);
        rd(ADDR_EVT, 32'h0000_0004);
        wr(ADDR_EVT, 32'h0000_0004);
    endtask

    // Inputs 1 and 3 stay disabled while their pins rise
    task automatic t_blocked();
        set_pin(1, 1'b1, 0);
        set_pin(3, 1'b1, 20);
        rd(ADDR_EVT, 32'h0000_0000);
        wr(ADDR_MODE, 32'h0000_0019);
        rd(ADDR_LVL, 32'h0000_0001);
        wr(ADDR_MODE, 32'h0000_0001);
        rd(ADDR_LVL, 32'h0000_000b);
        wr(ADDR_CTRL, 32'h0131_0001);
        repeat (20) @(posedge mclk);
        rd(ADDR_EVT, 32'h0000_0008);
        wr(ADDR_EVT, 32'h0000_0008);
    endtask

    // Sleep, Stop and Fail-Safe in turn; an undefined mode code leaves the mode alone
    task automatic t_modes();
        wr(ADDR_MODE, 32'h0000_0003);
        set_pin(0, 1'b0, 20);
        #1;
        chk({irq, wake_up}, 32'h0000_0001, "sleep wake-up");
        rd(ADDR_EVT, 32'h0000_0001);
        wr(ADDR_EVT, 32'h0000_0001);
        wr(ADDR_MODE, 32'h0000_0002);
        set_pin(0, 1'b1, 20);
        #1;
        chk({irq, wake_up}, 32'h0000_0002, "stop interrupt");
        wr(ADDR_EVT, 32'h0000_0001);
        wr(ADDR_MODE, 32'h0000_0004);
        set_pin(0, 1'b0, 20);
        #1;
        chk({irq, wake_up}, 32'h0000_0001, "fail-safe wake-up");
        set_pin(0, 1'b1, 20);
        wr(ADDR_EVT, 32'h0000_0001);
        wr(ADDR_MODE, 32'h0000_0007);
        rd(ADDR_MODE, 32'h0000_0004);
        wr(ADDR_MODE, 32'h0000_0002);
    endtask

    // Cyclic input 2 ignores its pin until its window opens
    task automatic t_cyclic();
        wr(ADDR_CTRL, 32'h0139_0001);
        set_pin(2, 1'b1, 20);
        rd(ADDR_EVT, 32'h0000_0000);
        rd(ADDR_LVL, 32'h0000_000b);
        @(posedge mclk);
        sense_window[2] <= 1'b1;
        repeat (20) @(posedge mclk);
        sense_window[2] <= 1'b0;
        rd(ADDR_EVT, 32'h0000_0004);
        rd(ADDR_LVL, 32'h0000_000f);
        wr(ADDR_EVT, 32'h0000_0004);
    endtask

    // Released pin 1 settles to whichever source the code selects
    task automatic t_pull();
        logic [3:0] exp_up;
        logic [3:0] exp_dn;
        exp_up = 4'hc;
        exp_dn = 4'h2;
        drive_en[1] <= 1'b0;
        for (int c = 0; c < 4; c++)
        begin
            wr(ADDR_CTRL, 32'h0031_0001 | (32'(c) << 9));
            repeat (6) @(posedge mclk);
            #1;
            chk({pull_up_en[1], pull_dn_en[1]}, {exp_up[c], exp_dn[c]}, "pull code");
        end
        @(posedge mclk);
        drive_en[1] <= 1'b1;
        set_pin(1, 1'b0, 6);
        #1;
        chk({pull_up_en[1], pull_dn_en[1]}, 32'h0000_0001, "auto pull low");
    endtask

    // Watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        report_and_stop();
    end

    // Unused inputs start tied low, input 0 high before entry to Normal
    initial
    begin
        drive_lvl <= 4'h1;
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_init_normal();
        t_edges();
        t_blocked();
        t_modes();
        t_cyclic();
        t_pull();
        report_and_stop();
    end
endmodule
